// >>> rtl/noc_pkg.sv
// Purpose: Shared constants and types of the opcode and namespace checker
// Assumes: One controller clock mclk, synchronous active-high reset rst
// Notes:   Register offsets are word indices on the plain register port
package noc_pkg;

  // ****************************************************************
  // Opcode fields and values
  // ****************************************************************
  localparam int          VENDOR_BIT     = 7;
  localparam int          FUNC_HI        = 6;
  localparam int          FUNC_LO        = 2;
  localparam int          DIR_HI         = 1;
  localparam int          DIR_LO         = 0;
  localparam logic [7:0]  OP_FLUSH       = 8'h00;
  localparam logic [7:0]  OP_WRITE       = 8'h01;
  localparam logic [7:0]  OP_READ        = 8'h02;
  localparam logic [7:0]  OP_WR_UNCOR    = 8'h04;
  localparam logic [7:0]  OP_COMPARE     = 8'h05;
  localparam logic [7:0]  OP_WR_ZEROES   = 8'h08;
  localparam logic [7:0]  OP_DSM         = 8'h09;
  localparam logic [7:0]  OP_RSV_REG     = 8'h0d;
  localparam logic [7:0]  OP_RSV_REPORT  = 8'h0e;
  localparam logic [7:0]  OP_RSV_ACQUIRE = 8'h11;
  localparam logic [7:0]  OP_RSV_RELEASE = 8'h15;

  // ****************************************************************
  // Namespace identifiers
  // ****************************************************************
  localparam int           NS_MAX       = 16;
  localparam int           NS_IDX_W     = 4;
  localparam logic [31:0]  NS_ID_BCAST  = 32'h0fffffff;
  localparam logic [31:0]  NS_ID_ZERO   = 32'h00000000;
  localparam int           LB_SHIFT_MIN = 9;

  // ****************************************************************
  // Completion status codes
  // ****************************************************************
  localparam logic [7:0]  ST_SUCCESS       = 8'h00;
  localparam logic [7:0]  ST_INV_OPCODE    = 8'h01;
  localparam logic [7:0]  ST_INV_FIELD     = 8'h02;
  localparam logic [7:0]  ST_INV_NS_FORMAT = 8'h0b;

  // ****************************************************************
  // Register map (word offsets)
  // ****************************************************************
  localparam logic [3:0]  RG_CTRL     = 4'h0;
  localparam logic [3:0]  RG_NUMNS    = 4'h1;
  localparam logic [3:0]  RG_ALLOC    = 4'h2;
  localparam logic [3:0]  RG_ATTACH   = 4'h3;
  localparam logic [3:0]  RG_OPTEN    = 4'h4;
  localparam logic [3:0]  RG_LBSHIFT  = 4'h5;
  localparam logic [3:0]  RG_RETRYLIM = 4'h6;
  localparam logic [3:0]  RG_IRQSTAT  = 4'h7;
  localparam logic [3:0]  RG_IRQMASK  = 4'h8;
  localparam logic [3:0]  RG_LAST     = 4'h9;
  localparam logic [3:0]  RG_COUNT    = 4'ha;

  // CTRL bits
  localparam int  CTRL_READY = 0;
  localparam int  CTRL_RSV   = 1;
  // OPTEN bits
  localparam int  OPT_WRUNC  = 0;
  localparam int  OPT_CMP    = 1;
  localparam int  OPT_WZ     = 2;
  localparam int  OPT_DSM    = 3;
  localparam int  OPT_VENDOR = 4;
  // IRQ bits
  localparam int  IRQ_DONE   = 0;
  localparam int  IRQ_OPC    = 1;
  localparam int  IRQ_NSINV  = 2;
  localparam int  IRQ_NSINA  = 3;
  localparam int  IRQ_NOTRDY = 4;
  localparam int  IRQ_W      = 5;

  // Reset values
  localparam logic [31:0]  NUMNS_RST    = 32'h00000001;
  localparam logic [4:0]   LBSHIFT_RST  = 5'h09;
  localparam logic [15:0]  RETRY_RST    = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_H2C  = 2'b01,
    DIR_C2H  = 2'b10,
    DIR_BIDI = 2'b11
  } noc_dir_t;

  typedef enum logic [2:0] {
    NS_INVALID  = 3'b000,
    NS_BCAST    = 3'b001,
    NS_ACTIVE   = 3'b010,
    NS_INACTIVE = 3'b011
  } noc_nskind_t;

  typedef struct packed {
    logic [7:0]   opcode;
    logic [15:0]  cmdId;
    logic [31:0]  namespace_identifier;
    logic         limitedRetry;
  } noc_cmd_t;

  typedef struct packed {
    logic          vendor;
    logic [4:0]    func;
    noc_dir_t      dir;
    logic          supported;
    logic          rsvCmd;
  } noc_dec_t;

  typedef struct packed {
    logic [15:0]   cmdId;
    logic [7:0]    status;
    noc_dir_t      dir;
    noc_nskind_t   nsKind;
    logic          dataXfer;
    logic          limitedRetry;
    logic [15:0]   retryLimit;
  } noc_cpl_t;

endpackage

// >>> rtl/noc_opcode_decode.sv
// Purpose: Split an opcode into its fields and judge whether it is served
// Assumes: Pure combinational, used by the checker core
// Notes:   Reserved opcodes report unsupported
module noc_opcode_decode (
  // Command
  input  wire logic [7:0]    opcode,
  // Options
  input  wire logic          rsvEnable,
  input  wire logic [4:0]    optEnable,
  // Result
  output noc_pkg::noc_dec_t  dec
);

  always_comb begin
    dec.vendor    = opcode[noc_pkg::VENDOR_BIT];
    dec.func      = opcode[noc_pkg::FUNC_HI:noc_pkg::FUNC_LO];
    dec.dir       = noc_pkg::noc_dir_t'(opcode[noc_pkg::DIR_HI:noc_pkg::DIR_LO]);
    dec.rsvCmd    = 1'b0;
    dec.supported = 1'b0;
    if (opcode[noc_pkg::VENDOR_BIT]) begin
      dec.supported = optEnable[noc_pkg::OPT_VENDOR];
    end else begin
      case (opcode)
        noc_pkg::OP_FLUSH,
        noc_pkg::OP_WRITE,
        noc_pkg::OP_READ:       dec.supported = 1'b1;
        noc_pkg::OP_WR_UNCOR:   dec.supported = optEnable[noc_pkg::OPT_WRUNC];
        noc_pkg::OP_COMPARE:    dec.supported = optEnable[noc_pkg::OPT_CMP];
        noc_pkg::OP_WR_ZEROES:  dec.supported = optEnable[noc_pkg::OPT_WZ];
        noc_pkg::OP_DSM:        dec.supported = optEnable[noc_pkg::OPT_DSM];
        noc_pkg::OP_RSV_REG,
        noc_pkg::OP_RSV_REPORT,
        noc_pkg::OP_RSV_ACQUIRE,
        noc_pkg::OP_RSV_RELEASE: begin
          dec.rsvCmd    = 1'b1;
          dec.supported = rsvEnable;
        end
        default:                dec.supported = 1'b0;
      endcase
    end
  end

endmodule

// >>> rtl/noc_check.sv
// Purpose: Opcode and namespace check front end for block-access commands
// Assumes: Commands arrive one per cycle as a strobe with a command struct
// Notes:   Verdict and completion appear one cycle after the strobe
//
// Summary of operation
// - Logical block size is a power of two, at least 512 bytes.
// - Limited retry bounds recovery by configured limit for listed commands.
// - Opcode bit 7 vendor flag, bits 6:2 function, bits 1:0 direction.
// - Direction 00 none, 01 to controller, 10 to host, 11 both.
// - Flush, write, read mandatory; others optional, gated by option bits.
// - Reservation opcodes served when reservation support is advertised.
// - Opcodes 80h-FFh vendor specific; other unlisted ones reserved.
// - Namespace field of dword 1 is checked for every command.
// - Valid identifier is nonzero and not above namespace count.
// - Value 0FFFFFFFh is broadcast, neither valid nor invalid.
// - Invalid identifier aborts with Invalid Namespace or Format.
// - Valid inactive identifier aborts with Invalid Field in Command.
// - Identifier active while attached; detach or delete makes inactive.
// - Identifier allocated while namespace exists; delete unallocates.
// - Logical blocks run from 0 to capacity minus one.
// - Any valid namespace reachable from any submission queue.
module noc_check (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Register port
  input  wire logic [3:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRdata,
  // Command in
  input  wire logic               cmdValid,
  input  wire logic [15:0]        cmdQueue,
  input  wire noc_pkg::noc_cmd_t  cmd,
  // Completion out
  output logic                    cplValid,
  output noc_pkg::noc_cpl_t       cpl,
  output logic                    cmdAccept,
  // Status
  output logic                    controllerReadyFlag,
  output logic                    irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                                 ready;
    logic                                 rsvEn;
    logic [31:0]                          numNs;
    logic [noc_pkg::NS_MAX-1:0]           alloc;
    logic [noc_pkg::NS_MAX-1:0]           attach;
    logic [4:0]                           optEn;
    logic [4:0]                           lbShift;
    logic [15:0]                          retryLim;
    logic [noc_pkg::IRQ_W-1:0]            irqStat;
    logic [noc_pkg::IRQ_W-1:0]            irqMask;
    logic [7:0]                           lastStatus;
    logic [31:0]                          rdata;
    logic                                 cplValid;
    noc_pkg::noc_cpl_t                    cpl;
    logic                                 irq;
    logic                                 accept;
  } noc_state_t;

  noc_state_t s_q;
  noc_state_t s_d;

  noc_pkg::noc_dec_t dec;

  noc_opcode_decode u_dec (
    .opcode    (cmd.opcode),
    .rsvEnable (s_q.rsvEn),
    .optEnable (s_q.optEn),
    .dec       (dec)
  );

  // ****************************************************************
  // Namespace classification
  // ****************************************************************
  logic                          nsValid;
  logic                          nsBcast;
  logic [noc_pkg::NS_IDX_W-1:0]  nsIdx;
  logic                          nsInRange;
  logic                          nsAttached;
  noc_pkg::noc_nskind_t          nsKind;
  logic [31:0]                   nsIdxFull;

  always_comb begin
    nsBcast    = (cmd.namespace_identifier == noc_pkg::NS_ID_BCAST);
    nsValid    = (cmd.namespace_identifier != noc_pkg::NS_ID_ZERO) && (cmd.namespace_identifier <= s_q.numNs) && !nsBcast;
    nsIdxFull  = cmd.namespace_identifier - 32'h00000001;
    nsIdx      = nsIdxFull[noc_pkg::NS_IDX_W-1:0];
    nsInRange  = (cmd.namespace_identifier <= 32'(noc_pkg::NS_MAX));
    nsAttached = nsInRange && s_q.attach[nsIdx];
    if (nsBcast) begin
      nsKind = noc_pkg::NS_BCAST;
    end else if (!nsValid) begin
      nsKind = noc_pkg::NS_INVALID;
    end else if (nsAttached) begin
      nsKind = noc_pkg::NS_ACTIVE;
    end else begin
      nsKind = noc_pkg::NS_INACTIVE;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [7:0]                  status;
  logic [noc_pkg::IRQ_W-1:0]   evt;
  logic                        retryCmd;
  logic [31:0]                 rd;

  always_comb begin
    s_d          = s_q;
    status       = noc_pkg::ST_SUCCESS;
    evt          = '0;
    retryCmd     = 1'b0;
    rd           = 32'h00000000;
    s_d.cplValid = 1'b0;
    s_d.accept   = 1'b1;

    if (cmdValid) begin
      if (!s_q.ready) begin
        status = noc_pkg::ST_INV_FIELD;
        evt[noc_pkg::IRQ_NOTRDY] = 1'b1;
      end else if (!dec.supported) begin
        status = noc_pkg::ST_INV_OPCODE;
        evt[noc_pkg::IRQ_OPC] = 1'b1;
      end else if (nsKind == noc_pkg::NS_INVALID) begin
        status = noc_pkg::ST_INV_NS_FORMAT;
        evt[noc_pkg::IRQ_NSINV] = 1'b1;
      end else if (nsKind == noc_pkg::NS_INACTIVE) begin
        status = noc_pkg::ST_INV_FIELD;
        evt[noc_pkg::IRQ_NSINA] = 1'b1;
      end
      evt[noc_pkg::IRQ_DONE] = 1'b1;
      case (cmd.opcode)
        noc_pkg::OP_COMPARE,
        noc_pkg::OP_READ,
        noc_pkg::OP_WRITE,
        noc_pkg::OP_WR_ZEROES: retryCmd = cmd.limitedRetry;
        default:               retryCmd = 1'b0;
      endcase
      s_d.cplValid         = 1'b1;
      s_d.cpl.cmdId        = cmd.cmdId;
      s_d.cpl.status       = status;
      s_d.cpl.dir          = dec.dir;
      s_d.cpl.nsKind       = nsKind;
      s_d.cpl.dataXfer     = (status == noc_pkg::ST_SUCCESS) && (dec.dir != noc_pkg::DIR_NONE);
      s_d.cpl.limitedRetry = retryCmd;
      s_d.cpl.retryLimit   = retryCmd ? s_q.retryLim : 16'h0000;
      s_d.lastStatus       = status;
    end

    // Register writes
    if (regWr) begin
      case (regAddr)
        noc_pkg::RG_CTRL: begin
          s_d.ready = regWdata[noc_pkg::CTRL_READY];
          s_d.rsvEn = regWdata[noc_pkg::CTRL_RSV];
        end
        noc_pkg::RG_NUMNS:    s_d.numNs = regWdata;
        noc_pkg::RG_ALLOC: begin
          s_d.alloc  = regWdata[noc_pkg::NS_MAX-1:0];
          s_d.attach = s_q.attach & regWdata[noc_pkg::NS_MAX-1:0];
        end
        noc_pkg::RG_ATTACH:   s_d.attach = regWdata[noc_pkg::NS_MAX-1:0] & s_q.alloc;
        noc_pkg::RG_OPTEN:    s_d.optEn = regWdata[4:0];
        // Block size at least 512 bytes
        noc_pkg::RG_LBSHIFT: begin
          if (regWdata[4:0] >= 5'(noc_pkg::LB_SHIFT_MIN)) begin
            s_d.lbShift = regWdata[4:0];
          end
        end
        noc_pkg::RG_RETRYLIM: s_d.retryLim = regWdata[15:0];
        noc_pkg::RG_IRQMASK:  s_d.irqMask = regWdata[noc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // Set wins over write-one clear
    if (regWr && (regAddr == noc_pkg::RG_IRQSTAT)) begin
      s_d.irqStat = (s_q.irqStat & ~regWdata[noc_pkg::IRQ_W-1:0]) | evt;
    end else begin
      s_d.irqStat = s_q.irqStat | evt;
    end

    // Register reads
    case (regAddr)
      noc_pkg::RG_CTRL: begin
        rd[noc_pkg::CTRL_READY] = s_q.ready;
        rd[noc_pkg::CTRL_RSV]   = s_q.rsvEn;
      end
      noc_pkg::RG_NUMNS:    rd = s_q.numNs;
      noc_pkg::RG_ALLOC:    rd[noc_pkg::NS_MAX-1:0] = s_q.alloc;
      noc_pkg::RG_ATTACH:   rd[noc_pkg::NS_MAX-1:0] = s_q.attach;
      noc_pkg::RG_OPTEN:    rd[4:0] = s_q.optEn;
      noc_pkg::RG_LBSHIFT:  rd[4:0] = s_q.lbShift;
      noc_pkg::RG_RETRYLIM: rd[15:0] = s_q.retryLim;
      noc_pkg::RG_IRQSTAT:  rd[noc_pkg::IRQ_W-1:0] = s_q.irqStat;
      noc_pkg::RG_IRQMASK:  rd[noc_pkg::IRQ_W-1:0] = s_q.irqMask;
      noc_pkg::RG_LAST:     rd[7:0] = s_q.lastStatus;
      default:              rd = 32'h00000000;
    endcase
    // Data stand only in the cycle after the read
    s_d.rdata = regRd ? rd : 32'h00000000;
    s_d.irq   = |(s_d.irqStat & s_d.irqMask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.numNs      <= noc_pkg::NUMNS_RST;
      s_q.lbShift    <= noc_pkg::LBSHIFT_RST;
      s_q.retryLim   <= noc_pkg::RETRY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdata            = s_q.rdata;
  assign cplValid            = s_q.cplValid;
  assign cpl                 = s_q.cpl;
  assign controllerReadyFlag = s_q.ready;
  assign irq                 = s_q.irq;
  // Never stalls; low through reset, high from its first edge after
  assign cmdAccept           = s_q.accept;

endmodule

// >>> sim/noc_check_sva.sv
// Purpose: Port checks of the opcode and namespace front end
// Assumes: One clock mclk, synchronous active-high rst
// Notes:   Sees only top ports; bound after the module
module noc_check_sva (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // Commands
  input wire logic               cmdValid,
  input wire noc_pkg::noc_cmd_t  cmd,
  input wire logic               controllerReadyFlag,
  // Completions
  input wire logic               cplValid,
  input wire noc_pkg::noc_cpl_t  cpl
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Ready command of one opcode
  sequence s_rdy(logic [7:0] op);
    cmdValid && controllerReadyFlag && cmd.opcode == op;
  endsequence

  a_cpl_follows: assert property (cmdValid |=> cplValid)
    else $error("completion missing");
  a_cpl_pulse: assert property (!cmdValid |=> !cplValid)
    else $error("completion without command");
  a_cmd_id: assert property (cmdValid |=> cpl.cmdId == $past(cmd.cmdId))
    else $error("completion id differs");
  a_dir_field: assert property (cmdValid |=> cpl.dir == $past(cmd.opcode[1:0]))
    else $error("direction field wrong");
  a_xfer_gate: assert property (cplValid |-> cpl.dataXfer ==
    (cpl.status == noc_pkg::ST_SUCCESS && cpl.dir != noc_pkg::DIR_NONE))
    else $error("transfer flag wrong");
  a_bcast_kind: assert property (s_rdy(noc_pkg::OP_WRITE) ##0
    cmd.namespace_identifier == noc_pkg::NS_ID_BCAST |=> cpl.nsKind == noc_pkg::NS_BCAST)
    else $error("broadcast not classed");
  a_not_ready: assert property (cmdValid && !controllerReadyFlag |=>
    cpl.status == noc_pkg::ST_INV_FIELD && !cpl.dataXfer)
    else $error("early command not aborted");
  a_reserved_op: assert property (s_rdy(8'h03) |=> cpl.status == noc_pkg::ST_INV_OPCODE)
    else $error("reserved opcode served");
  a_zero_ns: assert property (s_rdy(noc_pkg::OP_WRITE) ##0 cmd.namespace_identifier == 32'h0 |=>
    cpl.status == noc_pkg::ST_INV_NS_FORMAT)
    else $error("zero id not refused");
  a_flush_ok: assert property (s_rdy(noc_pkg::OP_FLUSH) ##0
    cmd.namespace_identifier == noc_pkg::NS_ID_BCAST |=> cpl.status == noc_pkg::ST_SUCCESS)
    else $error("flush refused");
endmodule

bind noc_check noc_check_sva i_noc_check_sva (.mclk, .rst, .cmdValid, .cmd,
  .controllerReadyFlag, .cplValid, .cpl);

// >>> sim/noc_host_model.sv
// Purpose: Host that submits commands to the front end
// Assumes: Calls start right after a rising edge
// Notes:   Idle command lines flip once per idle call so stale values never pass
module noc_host_model (
  // Clock and status
  input wire logic           mclk,
  input wire logic           controllerReadyFlag,
  // Command out
  output logic               cmdValid,
  output logic [15:0]        cmdQueue,
  output noc_pkg::noc_cmd_t  cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdQueue = 16'h0;
    cmd      = '0;
  end

  task automatic send(input logic [7:0] op, input logic [31:0] ns, input logic retryReq,
                      input logic [15:0] id, input logic early);
    for (int i = 0; i < 16 && !early && controllerReadyFlag !== 1'b1; i++) @(posedge mclk);
    cmdValid <= 1'b1;
    cmdQueue <= ~id;
    cmd      <= '{op, id, ns, retryReq};
    @(posedge mclk);
  endtask

  task automatic idle();
    cmdValid <= 1'b0;
    cmdQueue <= ~cmdQueue;
    cmd      <= ~cmd;
    @(posedge mclk);
  endtask
endmodule

// >>> sim/noc_check_tb.sv
// Purpose: Self-checking bench of the opcode and namespace front end
// Assumes: Expected results are queued by the drivers
// Notes:   Completions and reads are checked at the falling edge
module noc_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic [3:0]         regAddr = 4'h0;
  logic [31:0]        regWdata = 32'h0;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic [31:0]        regRdata;
  logic               cmdValid, cplValid, cmdAccept, controllerReadyFlag, irq;
  logic [15:0]        cmdQueue;
  noc_pkg::noc_cmd_t  cmd;
  noc_pkg::noc_cpl_t  cpl;
  noc_pkg::noc_cpl_t  expC[$];
  logic [31:0]        expR[$];
  logic               rdSeen = 1'b0;
  logic               live = 1'b0;
  logic               cfgRdy = 1'b0, cfgRsv = 1'b0;
  logic [4:0]         cfgOpt = 5'h0;
  logic [31:0]        cfgNum = 32'h1, cfgAtt = 32'h0;
  logic [15:0]        cfgLim = 16'h0;
  logic [31:0]        nsList[10] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h10, 32'h11,
                                     32'h14, 32'h15, 32'h0fffffff, 32'hffffffff};
  int                 fails = 0;
  int                 numChecks = 0;
  int                 seed = 32'h9bb577e2;

  always #5 mclk = ~mclk;

  noc_check i_noc_check (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .cmdValid, .cmdQueue, .cmd, .cplValid, .cpl, .cmdAccept, .controllerReadyFlag, .irq);
  noc_host_model i_noc_host_model (.mclk, .controllerReadyFlag, .cmdValid, .cmdQueue, .cmd);

  // ********
  // Compare and bus tasks
  // ********
  task automatic cmpWord(input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: word %h want %h", $time, g, e);
    end
  endtask

  task automatic cmpCpl(input noc_pkg::noc_cpl_t e, input noc_pkg::noc_cpl_t g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: completion %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expR.push_back(e);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic cmdOne(input logic [7:0] op, input logic [31:0] ns, input logic early);
    noc_pkg::noc_cpl_t e;
    logic sup;
    logic retryReq;
    e.cmdId = 16'($random(seed));
    retryReq = 1'($random(seed));
    sup = op < 8'h03 || (op == 8'h04 && cfgOpt[0]) || (op == 8'h05 && cfgOpt[1]) ||
          (op == 8'h08 && cfgOpt[2]) || (op == 8'h09 && cfgOpt[3]) || (op[7] && cfgOpt[4]) ||
          (cfgRsv && op inside {8'h0d, 8'h0e, 8'h11, 8'h15});
    e.nsKind = ns == 32'h0fffffff ? noc_pkg::NS_BCAST :
               (ns == 32'h0 || ns > cfgNum) ? noc_pkg::NS_INVALID :
               (ns < 32'h11 && cfgAtt[ns[4:0] - 5'h1]) ? noc_pkg::NS_ACTIVE : noc_pkg::NS_INACTIVE;
    e.status = !cfgRdy ? 8'h02 : !sup ? 8'h01 : e.nsKind == noc_pkg::NS_INVALID ? 8'h0b :
               e.nsKind == noc_pkg::NS_INACTIVE ? 8'h02 : 8'h00;
    e.dir = noc_pkg::noc_dir_t'(op[1:0]);
    e.dataXfer = e.status == 8'h00 && op[1:0] != 2'b00;
    e.limitedRetry = retryReq && op inside {8'h01, 8'h02, 8'h05, 8'h08};
    e.retryLimit = e.limitedRetry ? cfgLim : 16'h0;
    expC.push_back(e);
    i_noc_host_model.send(op, ns, retryReq, e.cmdId, early);
  endtask

  task automatic irqIs(input logic v);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    cmpWord({31'h0, v}, {31'h0, irq});
    @(posedge mclk);
  endtask

  task automatic closeOut();
    if (expC.size() + expR.size() != 0) fails++;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ********
  // Result watcher and stimulus
  // ********
  always @(posedge mclk) rdSeen <= regRd;
  always @(posedge mclk) live <= !rst;
  always @(negedge mclk) begin
    if (cplValid === 1'b1 && expC.size() > 0) cmpCpl(expC.pop_front(), cpl);
    else if (cplValid !== 1'b0) cmpWord(32'h0, 32'h1);
    if (rdSeen && expR.size() > 0) cmpWord(expR.pop_front(), regRdata);
    // Acceptance rises one edge after reset leaves
    if (live) cmpWord(32'h1, {31'h0, cmdAccept});
    else cmpWord(32'h0, {31'h0, cmdAccept});
  end

  initial begin
    repeat (50000) @(posedge mclk);
    fails++;
    closeOut();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(noc_pkg::RG_NUMNS, 32'h1);
    rd(4'hf, 32'h0);
    wr(noc_pkg::RG_LBSHIFT, 32'h8);
    rd(noc_pkg::RG_LBSHIFT, 32'h9);
    wr(noc_pkg::RG_LBSHIFT, 32'hc);
    rd(noc_pkg::RG_LBSHIFT, 32'hc);
    cmdOne(noc_pkg::OP_READ, 32'h1, 1'b1);
    i_noc_host_model.idle();
    $display("test regs_and_early done");
    cfgNum = 32'h14;
    cfgLim = 16'($random(seed));
    cfgAtt = 32'h8005;
    wr(noc_pkg::RG_NUMNS, cfgNum);
    wr(noc_pkg::RG_RETRYLIM, {16'h0, cfgLim});
    wr(noc_pkg::RG_ALLOC, 32'hffff);
    wr(noc_pkg::RG_ATTACH, cfgAtt);
    for (int p = 0; p < 3; p++) begin
      cfgRdy = 1'b1;
      cfgRsv = p[0];
      cfgOpt = p == 2 ? 5'h1f : p == 1 ? 5'($random(seed)) : 5'h0;
      wr(noc_pkg::RG_CTRL, {30'h0, cfgRsv, 1'b1});
      wr(noc_pkg::RG_OPTEN, {27'h0, cfgOpt});
      for (int op = 0; op < 256; op++) cmdOne(op[7:0], 32'h1, 1'b0);
      i_noc_host_model.idle();
    end
    $display("test opcode_sweep done");
    foreach (nsList[i]) cmdOne(noc_pkg::OP_WRITE, nsList[i], 1'b0);
    cmdOne(noc_pkg::OP_FLUSH, 32'h0fffffff, 1'b0);
    repeat (12) cmdOne(noc_pkg::OP_READ, 32'($random(seed)) & 32'h1f, 1'b0);
    i_noc_host_model.idle();
    cfgAtt = 32'h8004;
    wr(noc_pkg::RG_ALLOC, 32'hfffe);
    wr(noc_pkg::RG_ALLOC, 32'hffff);
    cmdOne(noc_pkg::OP_READ, 32'h1, 1'b0);
    i_noc_host_model.idle();
    $display("test namespaces done");
    wr(noc_pkg::RG_IRQSTAT, 32'h1f);
    wr(noc_pkg::RG_IRQMASK, 32'h2);
    cmdOne(8'h03, 32'h1, 1'b0);
    i_noc_host_model.idle();
    irqIs(1'b1);
    wr(noc_pkg::RG_IRQSTAT, 32'h2);
    irqIs(1'b0);
    wr(noc_pkg::RG_IRQMASK, 32'h0);
    cmdOne(8'h03, 32'h1, 1'b0);
    i_noc_host_model.idle();
    irqIs(1'b0);
    $display("test interrupt done");
    repeat (4) @(posedge mclk);
    closeOut();
  end
endmodule
